// >>> logic/adsc_conv_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module adsc_conv_ctrl
    import adsc_pkg::*;
#(
    parameter int RES = adsc_pkg::RES_DEFAULT,
    parameter int FIFO_DEPTH = adsc_pkg::FIFO_DEPTH_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Result stream from the quantiser
    input wire logic [RES-1:0] sampleData,
    input wire logic sampleValid,
    output logic sampleReady,
    // Serial link pins
    input wire logic serialClk,
    input wire logic chipSelN,
    output logic serialResultOut,
    output logic serialResultOutEnN,
    // Status
    output logic powerDown,
    output logic convStart,
    output logic convDone,
    output logic convAbort,
    output logic sampleMissed
);
    import adsc_pkg::*;

    localparam int PAD = WORD_BITS - LEAD_ZEROS - RES;

    generate
        if (RES != 12 && RES != 10 && RES != 8) begin : g_bad_res
            $error("adsc_conv_ctrl: RES must be 12, 10 or 8");
        end
    endgenerate

    // ---------------- Reference clock side ----------------
    logic csS;
    logic csActS;
    logic sclkS;
    logic csD_q;
    logic sclkD_q;
    logic csFall;
    logic csRise;
    logic sclkFall;
    logic [4:0] edgeCnt_q;
    adsc_state_t state_q;
    logic powerDown_q;
    logic [WORD_BITS-1:0] frameWord_q;
    logic [RES-1:0] fifoData;
    logic fifoValid;
    logic fifoPop;
    logic [WORD_BITS-1:0] paddedWord;
    logic frameStart;
    logic frameEnd;

    adsc_sync #(.WIDTH(2)) u_pin_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .ce(clkEn),
        .async({~chipSelN, serialClk}),
        .synced({csActS, sclkS})
    );

    // Select travels inverted so the zero reset of the synchroniser
    // reads as an idle, deselected pin
    assign csS = !csActS;

    adsc_fifo #(.WIDTH(RES), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst(sys_rst),
        .ce(clkEn),
        .inData(sampleData),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoPop)
    );

    // Reset levels equal the synchronised idle levels, so release is no edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            csD_q <= 1'b1;
            sclkD_q <= 1'b0;
        end else if (clkEn) begin
            csD_q <= csS;
            sclkD_q <= sclkS;
        end
    end

    assign csFall = csD_q && !csS;
    assign csRise = !csD_q && csS;
    assign sclkFall = sclkD_q && !sclkS;
    assign frameStart = state_q == ST_IDLE && csFall;
    assign frameEnd = state_q == ST_FRAME && csRise;

    // Leading zeros, result MSB first, zero padding at the tail; a shift
    // avoids a zero-width replication when there is no padding
    assign paddedWord = WORD_BITS'(fifoData) << PAD;

    // Sample taken only in normal mode; a dummy frame consumes nothing
    assign fifoPop = clkEn && state_q == ST_IDLE && csFall && !powerDown_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            edgeCnt_q <= 5'h00;
        end else if (clkEn) begin
            if (csFall) begin
                edgeCnt_q <= 5'h00;
            end else if (!csS && sclkFall && edgeCnt_q < EDGE_FULL) begin
                edgeCnt_q <= edgeCnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frameWord_q <= RST_WORD;
        end else if (clkEn && state_q == ST_IDLE && csFall) begin
            // Dummy frames and underruns shift out an all-zero word
            if (!powerDown_q && fifoValid) begin
                frameWord_q <= paddedWord;
            end else begin
                frameWord_q <= RST_WORD;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else if (clkEn) begin
            case (state_q)
                ST_IDLE: begin
                    if (csFall) begin
                        state_q <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (csRise) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // The mode changes only at a chip select rise that ends a frame
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            powerDown_q <= RST_POWER_DOWN;
        end else if (clkEn && state_q == ST_FRAME && csRise) begin
            if (powerDown_q) begin
                if (edgeCnt_q >= EDGE_KEEP) begin
                    powerDown_q <= 1'b0;
                end else begin
                    powerDown_q <= 1'b1;
                end
            end else if (edgeCnt_q >= EDGE_PD_MIN && edgeCnt_q < EDGE_KEEP) begin
                powerDown_q <= 1'b1;
            end else begin
                powerDown_q <= 1'b0;
            end
        end
    end

    // Pulses drop while frozen, so a held enable never doubles a count
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            convStart <= 1'b0;
        end else begin
            convStart <= clkEn && frameStart && !powerDown_q;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sampleMissed <= 1'b0;
        end else begin
            sampleMissed <= fifoPop && !fifoValid;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            convDone <= 1'b0;
        end else begin
            convDone <= clkEn && frameEnd && !powerDown_q
                && edgeCnt_q == EDGE_FULL;
        end
    end

    // Dummy frames in power-down end silently, whatever their length
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            convAbort <= 1'b0;
        end else begin
            convAbort <= clkEn && frameEnd && !powerDown_q
                && edgeCnt_q != EDGE_FULL;
        end
    end

    assign powerDown = powerDown_q;

    // ---------------- Serial clock side ----------------
    // Chip select high clears the frame, so no serial clock edge is needed
    // outside a frame. frameWord_q is loaded a few reference cycles after
    // the fall and read from the first falling edge on, while it is
    // held constant for the whole frame.
    logic [4:0] bitCnt_q;
    logic [3:0] bitIdx;

    assign bitIdx = 4'(WORD_BITS - 2) - bitCnt_q[3:0];

    always_ff @(negedge serialClk or posedge chipSelN or posedge sys_rst) begin
        if (sys_rst || chipSelN) begin
            bitCnt_q <= 5'h00;
        end else if (bitCnt_q < EDGE_FULL) begin
            bitCnt_q <= bitCnt_q + 5'h01;
        end
    end

    // First bit is a leading zero, so it can be a reset constant
    always_ff @(negedge serialClk or posedge chipSelN or posedge sys_rst) begin
        if (sys_rst || chipSelN) begin
            serialResultOut <= 1'b0;
        end else if (bitCnt_q < EDGE_FULL - 5'h01) begin
            serialResultOut <= frameWord_q[bitIdx];
        end else begin
            serialResultOut <= 1'b0;
        end
    end

    // Driven only while selected and before the word is complete
    assign serialResultOutEnN = sys_rst || chipSelN
        || bitCnt_q == EDGE_FULL;
endmodule : adsc_conv_ctrl
`default_nettype wire

// >>> logic/adsc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module adsc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("adsc_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign inReady = (count_q != (AW+1)'(DEPTH)) && ce;
    assign outValid = (count_q != '0) && ce;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + AW'(1);
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + AW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end
endmodule : adsc_fifo
`default_nettype wire

// >>> logic/adsc_pkg.sv
package adsc_pkg;
    // Serial word layout and default sizes
    localparam int WORD_BITS = 16;
    localparam int LEAD_ZEROS = 4;
    localparam int RES_DEFAULT = 12;
    localparam int FIFO_DEPTH_DEFAULT = 8;
    // Falling-edge counts that steer the power mode and mark a full frame
    localparam logic [4:0] EDGE_PD_MIN = 5'h02;
    localparam logic [4:0] EDGE_KEEP = 5'h0A;
    localparam logic [4:0] EDGE_FULL = 5'h10;
    // Values after reset
    localparam logic RST_POWER_DOWN = 1'b0;
    localparam logic [WORD_BITS-1:0] RST_WORD = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FRAME = 2'b10
    } adsc_state_t;
endpackage : adsc_pkg

// >>> logic/adsc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module adsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            synced <= '0;
        end else if (ce) begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule : adsc_sync
`default_nettype wire

// >>> testbench/adsc_conv_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module adsc_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic chipSelN,
    input wire logic serialResultOut,
    input wire logic serialResultOutEnN,
    input wire logic powerDown,
    input wire logic convStart,
    input wire logic convDone,
    input wire logic convAbort
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    a_idle_released: assert property (
        chipSelN |-> serialResultOutEnN) else $error("driven while idle");
    a_idle_low: assert property (
        chipSelN |-> !serialResultOut) else $error("data not low when idle");
    a_pulse_excl: assert property (
        convDone |-> !convAbort && !convStart) else $error("pulses overlap");
    a_start_single: assert property (
        convStart |=> !convStart) else $error("start too long");
    a_done_late: assert property (
        convDone |-> chipSelN && $past(chipSelN, 2)) else $error("early done");
    a_mode_at_rise: assert property (
        !$stable(powerDown) |-> chipSelN) else $error("mode moved in frame");
    a_start_normal: assert property (
        convStart |-> !powerDown) else $error("start while down");
    a_down_word_zero: assert property (
        powerDown && !serialResultOutEnN |-> !serialResultOut)
        else $error("data while down");
    a_abort_deselect: assert property (
        convAbort |-> chipSelN) else $error("abort while selected");
    c_done: cover property (convDone);
    c_enter_down: cover property ($rose(powerDown));
    c_wake: cover property ($fell(powerDown));
endmodule : adsc_chk
bind adsc_conv_ctrl adsc_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .chipSelN(chipSelN), .serialResultOut(serialResultOut),
    .serialResultOutEnN(serialResultOutEnN), .powerDown(powerDown),
    .convStart(convStart), .convDone(convDone), .convAbort(convAbort));
`default_nettype wire

// >>> testbench/adsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adsc_host_model (
    output logic chipSelN,
    output logic serialClk,
    input wire logic serialResultOut,
    input wire logic serialResultOutEnN
);
    logic last = 1'b0;
    // A released line reads as the inverse of its last level
    function automatic logic rx();
        return serialResultOutEnN ? ~last : serialResultOut;
    endfunction : rx
    initial begin
        chipSelN = 1'b1;
        serialClk = 1'b1;
    end
    // Clock stands high outside frames; unread bits stay zero
    task automatic frame(input int e, output logic [15:0] w);
        w = 16'h0000;
        #3 chipSelN = 1'b0;
        #40 w[15] = rx();
        last = w[15];
        for (int k = 1; k <= e; k++) begin
            serialClk = 1'b0;
            #15 serialClk = 1'b1;
            if (k < 16) w[15-k] = rx();
            last = w[15-(k%16)];
            #15;
        end
        chipSelN = 1'b1;
        #90;
    endtask : frame
endmodule : adsc_host_model
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic [11:0] sampleData = 12'h000;
    logic sampleValid = 1'b0;
    logic sampleReady, serialClk, chipSelN, serialResultOut;
    logic serialResultOutEnN, powerDown, convStart, convDone, convAbort;
    logic sampleMissed;
    logic serialOut10, outEnN10, serialOut8, outEnN8;
    logic [15:0] w10 = 16'h0000;
    logic [15:0] w8 = 16'h0000;
    int fail_count = 0;
    int checks_done = 0;
    int nDone = 0, nAbort = 0, nMiss = 0, nStart = 0;
    adsc_conv_ctrl #(.RES(12), .FIFO_DEPTH(8)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .sampleData(sampleData), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .serialClk(serialClk),
        .chipSelN(chipSelN), .serialResultOut(serialResultOut),
        .serialResultOutEnN(serialResultOutEnN), .powerDown(powerDown),
        .convStart(convStart), .convDone(convDone), .convAbort(convAbort),
        .sampleMissed(sampleMissed));
    adsc_host_model host (.chipSelN(chipSelN), .serialClk(serialClk),
        .serialResultOut(serialResultOut),
        .serialResultOutEnN(serialResultOutEnN));
    // Narrower variants share the link and the stream, fed the top bits
    adsc_conv_ctrl #(.RES(10), .FIFO_DEPTH(8)) DUT10 (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .sampleData(sampleData[11:2]), .sampleValid(sampleValid),
        .sampleReady(), .serialClk(serialClk), .chipSelN(chipSelN),
        .serialResultOut(serialOut10), .serialResultOutEnN(outEnN10),
        .powerDown(), .convStart(), .convDone(), .convAbort(),
        .sampleMissed());
    adsc_conv_ctrl #(.RES(8), .FIFO_DEPTH(8)) DUT8 (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .sampleData(sampleData[11:4]), .sampleValid(sampleValid),
        .sampleReady(), .serialClk(serialClk), .chipSelN(chipSelN),
        .serialResultOut(serialOut8), .serialResultOutEnN(outEnN8),
        .powerDown(), .convStart(), .convDone(), .convAbort(),
        .sampleMissed());
    // Bit 15 is a lead zero shown before any clock, so it is not shifted in
    always @(posedge serialClk) begin
        if (outEnN10 === 1'b0)
            w10 <= {w10[14:0], serialOut10};
        if (outEnN8 === 1'b0)
            w8 <= {w8[14:0], serialOut8};
    end
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        nDone <= nDone + int'(convDone === 1'b1);
        nAbort <= nAbort + int'(convAbort === 1'b1);
        nMiss <= nMiss + int'(sampleMissed === 1'b1);
        nStart <= nStart + int'(convStart === 1'b1);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Pulses are counted, so late or doubled ones show as a count error
    task automatic run(input int e, input logic [15:0] ew, input logic pd,
            input int dd, input int da);
        logic [15:0] w;
        int d0, a0, s0;
        d0 = nDone;
        a0 = nAbort;
        s0 = nStart;
        host.frame(e, w);
        repeat (10) @(posedge ref_clk);
        #1;
        chk(w, ew);
        chk({15'h0000, powerDown}, {15'h0000, pd});
        chk(16'(nDone - d0), 16'(dd));
        chk(16'(nAbort - a0), 16'(da));
        chk(16'(nStart - s0), 16'(dd + da));
        chk({15'h0000, serialResultOutEnN}, 16'h0001);
    endtask : run
    task automatic t_glitch();
        run(1, 16'h0000, 1'b0, 0, 1);
    endtask : t_glitch
    task automatic t_fill_drain();
        logic [15:0] ew;
        sampleValid = 1'b1;
        for (int i = 0; i < 8; i++) begin
            sampleData = 12'h9A5 ^ (12'(i) * 12'h111);
            chk({15'h0000, sampleReady}, 16'h0001);
            @(posedge ref_clk);
            #1;
        end
        chk({15'h0000, sampleReady}, 16'h0000);
        sampleValid = 1'b0;
        for (int i = 0; i < 8; i++) begin
            ew = {4'h0, 12'h9A5 ^ (12'(i) * 12'h111)};
            run(16, ew, 1'b0, 1, 0);
            chk({1'b0, w10[14:0]}, ew & 16'h0FFC);
            chk({1'b0, w8[14:0]}, ew & 16'h0FF0);
        end
    endtask : t_fill_drain
    task automatic t_underrun();
        int m0;
        m0 = nMiss;
        run(16, 16'h0000, 1'b0, 1, 0);
        chk(16'(nMiss - m0), 16'h0001);
    endtask : t_underrun
    task automatic t_abort_keep();
        run(12, 16'h0000, 1'b0, 0, 1);
    endtask : t_abort_keep
    task automatic t_pd_enter();
        run(5, 16'h0000, 1'b1, 0, 1);
    endtask : t_pd_enter
    task automatic t_wake_fail();
        run(8, 16'h0000, 1'b1, 0, 0);
    endtask : t_wake_fail
    task automatic t_wake();
        run(16, 16'h0000, 1'b0, 0, 0);
        sampleData = 12'h5A3;
        sampleValid = 1'b1;
        @(posedge ref_clk);
        #1;
        sampleValid = 1'b0;
        run(16, 16'h05A3, 1'b0, 1, 0);
        chk({1'b0, w10[14:0]}, 16'h05A0);
        chk({1'b0, w8[14:0]}, 16'h05A0);
    endtask : t_wake
    task automatic results();
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(16'(nStart + nAbort + nMiss), 16'h0000);
        t_glitch();
        t_fill_drain();
        t_underrun();
        t_abort_keep();
        t_pd_enter();
        t_wake_fail();
        t_wake();
        results();
    end
    // Whole run needs about 10 us
    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule : tb
`default_nettype wire
